// ---- verilog/diag_status_pkg.sv ----
// Addresses, field layouts and reset values of the diag status bank.
`default_nettype none
package diag_status_pkg;
    localparam logic [6:0] ADDR_OV_FLAGS = 7'h52;
    localparam logic [6:0] ADDR_DELAY_HB1 = 7'h53;
    localparam logic [6:0] ADDR_DELAY_HB2 = 7'h54;
    localparam logic [6:0] ADDR_DELAY_HB3 = 7'h55;
    localparam int OV_FLAG_COUNT = 6;
    localparam int ON_LSB = 0;
    localparam int OFF_LSB = 8;
    localparam int COUNT_WIDTH = 6;
    localparam int HB_COUNT = 3;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] OV_FLAG_MASK = 16'h003f;
    localparam logic [15:0] DELAY_MASK = 16'h3f3f;
    localparam real COUNT_STEP_NS = 53.3;
endpackage
`default_nettype wire

// ---- verilog/gate_driver_diag_status_regs.sv ----
// Read-only diagnostic status registers of the half-bridge gate driver.
`default_nettype none
// What this block does
// - Six overvoltage flags sit in bits 0 to 5, high then low side.
// - Each flag is sticky and a read returns it and then clears it.
// - Power-on or soft reset zeroes the whole overvoltage register.
// - A restart zeroes overvoltage bits 15 and 14 and keeps the flags.
// - Bridge 1 turn-on delay count is reported in bits 5 to 0.
// - Bridge 1 turn-off delay count is reported in bits 13 to 8.
// - Bridge 2 reports turn-on in bits 5 to 0, turn-off in bits 13 to 8.
// - Bridge 3 reports turn-off in bits 13 to 8, turn-on in bits 5 to 0.
// - Delay register bits 15, 14, 7 and 6 always read zero.
// - Host writes never change the delay registers.
// - Reset zeroes delays; restart zeroes only reserved bits.
// - Delay registers of bridges 1 to 3 are at addresses 0x53 to 0x55.
// - Overvoltage register sits at 0x52, its bits 15 and 14 read zero.
//
// All registers are read-only from the host side. The write strobe and the
// write data are accepted on the ports only so that the bus looks complete;
// nothing in this block ever samples them into state.
//
// Reads are answered one cycle after the strobe with a one-cycle valid
// pulse. Back-to-back reads are allowed, one answer per strobe.
module gate_driver_diag_status_regs
    import diag_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic soft_reset,
    input wire logic restart,
    input wire logic [5:0] ov_detect,
    input wire logic [2:0] meas_valid,
    input wire logic [17:0] meas_on_count,
    input wire logic [17:0] meas_off_count,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [6:0] addr,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data_ff,
    output logic rd_valid_ff
);
    logic [15:0] ov_ff, nxt_ov;
    logic [15:0] dly_ff [HB_COUNT];
    logic [15:0] nxt_dly [HB_COUNT];
    logic [15:0] nxt_rd_data;
    logic nxt_rd_valid;
    logic ov_read;

    function automatic logic [15:0] pack_delay(input logic [5:0] on_c,
                                               input logic [5:0] off_c);
        // Starting from zero keeps the reserved gaps clear by construction.
        pack_delay = REG_RESET;
        pack_delay[ON_LSB +: COUNT_WIDTH] = on_c;
        pack_delay[OFF_LSB +: COUNT_WIDTH] = off_c;
    endfunction

    assign ov_read = rd_en && (addr == ADDR_OV_FLAGS);

    always_comb begin
        // Detection wins over the read clear so a fault in that cycle stays.
        nxt_ov = ov_read ? REG_RESET : ov_ff;
        nxt_ov = nxt_ov | ({10'h000, ov_detect} & OV_FLAG_MASK);
        if (soft_reset) begin
            nxt_ov = REG_RESET;
        end else if (restart) begin
            // A restart must not swallow a fault seen in the same cycle.
            nxt_ov = nxt_ov & OV_FLAG_MASK;
        end
        for (int i = 0; i < HB_COUNT; i++) begin
            // The write port is deliberately ignored here.
            nxt_dly[i] = dly_ff[i] & DELAY_MASK;
            if (meas_valid[i]) begin
                nxt_dly[i] = pack_delay(meas_on_count[i*6 +: 6],
                                        meas_off_count[i*6 +: 6]);
            end
            if (soft_reset) begin
                nxt_dly[i] = REG_RESET;
            end else if (restart) begin
                nxt_dly[i] = dly_ff[i] & DELAY_MASK;
            end
        end
    end

    always_comb begin
        nxt_rd_valid = rd_en;
        nxt_rd_data = REG_RESET;
        if (rd_en) begin
            unique case (addr)
                ADDR_OV_FLAGS: nxt_rd_data = ov_ff & OV_FLAG_MASK;
                ADDR_DELAY_HB1: nxt_rd_data = dly_ff[0] & DELAY_MASK;
                ADDR_DELAY_HB2: nxt_rd_data = dly_ff[1] & DELAY_MASK;
                ADDR_DELAY_HB3: nxt_rd_data = dly_ff[2] & DELAY_MASK;
                default: nxt_rd_data = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ov_ff <= REG_RESET;
            for (int i = 0; i < HB_COUNT; i++) begin
                dly_ff[i] <= REG_RESET;
            end
            rd_data_ff <= REG_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            ov_ff <= nxt_ov;
            for (int i = 0; i < HB_COUNT; i++) begin
                dly_ff[i] <= nxt_dly[i];
            end
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // Every check below lives in the one core clock domain, so the clock
    // and the reset qualifier are given once here for all of them.
    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // A fault detected on flag 0 must be visible in the register one edge later.
    chk_ov_sticky: assert property (
        (ov_detect[0] && !soft_reset) |=> ov_ff[0])
        else $error("overvoltage flag not captured");

    // With nothing new detected, a read leaves every flag cleared.
    chk_ov_read_clear: assert property (
        (ov_read && ov_detect == 6'h00 && !soft_reset)
            |=> ov_ff == REG_RESET)
        else $error("read did not clear flags");

    // The host sees the flags as they stood before the clear.
    chk_ov_read_data: assert property (
        ov_read |=> rd_valid_ff
            && rd_data_ff == ($past(ov_ff) & OV_FLAG_MASK))
        else $error("read data is not prior flags");

    // Flags only move on a detect, a read or a reset.
    chk_ov_hold: assert property (
        (!ov_read && ov_detect == 6'h00 && !soft_reset) |=> $stable(ov_ff))
        else $error("flags changed without cause");

    // The reserved top bits of the flag register never get set.
    chk_ov_reserved: assert property (
        ov_ff[15:14] == 2'b00)
        else $error("overvoltage reserved bits set");

    chk_soft_reset_zero: assert property (
        soft_reset |=> ov_ff == REG_RESET && dly_ff[0] == REG_RESET)
        else $error("soft reset left state");

    // Only a quiet restart is checked for keeping the flags unchanged.
    chk_restart_keep: assert property (
        (restart && !soft_reset && !ov_read && ov_detect == 6'h00)
            |=> ov_ff == ($past(ov_ff) & OV_FLAG_MASK))
        else $error("restart changed flags");

    // A restart keeps both delay fields of a bridge.
    chk_restart_delay: assert property (
        (restart && !soft_reset)
            |=> dly_ff[0] == ($past(dly_ff[0]) & DELAY_MASK))
        else $error("restart changed delay fields");

    chk_delay_reserved: assert property (
        rd_valid_ff |-> (rd_data_ff & 16'hc0c0) == 16'h0000)
        else $error("reserved bits read nonzero");

    chk_delay_update: assert property (
        (meas_valid[1] && !soft_reset && !restart) |=>
            dly_ff[1][13:8] == $past(meas_off_count[11:6]))
        else $error("delay field not refreshed");

    chk_delay_ro: assert property (
        (wr_en && meas_valid == 3'h0 && !soft_reset) |=> $stable(dly_ff[2]))
        else $error("write changed delay register");

    chk_hb1_read: assert property (
        (rd_en && addr == ADDR_DELAY_HB1)
            |=> rd_data_ff[5:0] == $past(dly_ff[0][5:0]))
        else $error("hb1 read mismatch");

    chk_hb2_read: assert property (
        (rd_en && addr == ADDR_DELAY_HB2)
            |=> rd_data_ff == ($past(dly_ff[1]) & DELAY_MASK))
        else $error("hb2 read mismatch");

    chk_hb3_read: assert property (
        (rd_en && addr == ADDR_DELAY_HB3)
            |=> rd_data_ff == ($past(dly_ff[2]) & DELAY_MASK))
        else $error("hb3 read mismatch");

    // One answer per strobe, exactly one cycle later.
    chk_read_pulse: assert property (
        rd_valid_ff == $past(rd_en))
        else $error("read valid not one cycle after strobe");

    // The data lines stay at zero between answers.
    chk_idle_quiet: assert property (
        !rd_valid_ff |-> rd_data_ff == REG_RESET)
        else $error("read data not zero while idle");

    cov_ov_read: cover property (
        ov_ff[5] ##1 ov_read);
    cov_restart: cover property (
        restart && ov_ff != REG_RESET);
    cov_meas: cover property (
        meas_valid[2] ##1 rd_en && addr == ADDR_DELAY_HB3);
    cov_soft_reset: cover property (
        soft_reset && dly_ff[0] != REG_RESET);
    cov_write: cover property (
        wr_en && addr == ADDR_DELAY_HB2);
endmodule // gate_driver_diag_status_regs
`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model issuing single register reads and writes.
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic [15:0] rd_data_ff,
    input wire logic rd_valid_ff,
    output logic rd_en,
    output logic wr_en,
    output logic [6:0] addr,
    output logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {rd_en, wr_en, addr, wr_data} = '0;
    // Data is taken while valid stands, so a missing answer reads unknown.
    task automatic access(input logic w, input logic [6:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(negedge core_clk);
        {rd_en, wr_en, addr, wr_data} = {~w, w, a, d};
        @(negedge core_clk);
        q = rd_valid_ff ? rd_data_ff : 16'hxxxx;
        {rd_en, wr_en} = 2'b00;
    endtask
endmodule // host_model
`default_nettype wire

// ---- bench/test_gate_driver_diag_status_regs.sv ----
// Self-checking testbench of the diagnostic status register bank.
`default_nettype none
module test_gate_driver_diag_status_regs;
    import diag_status_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst_b = 1'b0, soft_reset = 1'b0, restart = 1'b0;
    logic [5:0] ov_detect = '0;
    logic [2:0] meas_valid = '0;
    logic [17:0] meas_on_count = '0, meas_off_count = '0;
    logic rd_en, wr_en, rd_valid_ff;
    logic [6:0] addr;
    logic [15:0] wr_data, rd_data_ff, q;
    int mismatches = 0, n_compared = 0, cycles = 0;
    always #12.5 core_clk = ~core_clk;
    gate_driver_diag_status_regs i_dut (.core_clk, .rst_b, .soft_reset,
        .restart, .ov_detect, .meas_valid, .meas_on_count, .meas_off_count,
        .rd_en, .wr_en, .addr, .wr_data, .rd_data_ff, .rd_valid_ff);
    host_model i_host (.core_clk, .rd_data_ff, .rd_valid_ff, .rd_en, .wr_en,
        .addr, .wr_data);
    task automatic chk(input string n, input logic [15:0] e);
        n_compared++;
        if (q !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, q);
            mismatches++;
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset();
        for (int a = 'h52; a < 'h56; a++) begin
            i_host.access(1'b0, 7'(a), '0, q);
            chk("reset", REG_RESET);
        end
        $display("test reset done");
    endtask
    task automatic t_delay();
        @(negedge core_clk);
        {meas_on_count, meas_off_count} = {18'h3f541, 18'h2a03f};
        meas_valid = 3'b111;
        @(negedge core_clk);
        meas_valid = 3'b000;
        for (int i = 0; i < 3; i++) i_host.access(1'b1, 7'('h53 + i), '1, q);
        restart = 1'b1;
        @(negedge core_clk);
        restart = 1'b0;
        for (int i = 0; i < 3; i++) begin
            logic [15:0] e;
            e = {2'b00, meas_off_count[6*i+:6], 2'b00, meas_on_count[6*i+:6]};
            i_host.access(1'b0, 7'('h53 + i), '0, q);
            chk("delay", e);
            chk("delay kept", e);
        end
        i_host.access(1'b0, 7'h60, '0, q);
        chk("unmapped", 16'h0000);
        $display("test delay done");
    endtask
    task automatic t_flags();
        @(negedge core_clk);
        ov_detect = 6'h2d;
        @(negedge core_clk);
        {ov_detect, restart} = 7'h01;
        @(negedge core_clk);
        restart = 1'b0;
        i_host.access(1'b0, ADDR_OV_FLAGS, '0, q);
        chk("flags", 16'h002d);
        i_host.access(1'b0, ADDR_OV_FLAGS, '0, q);
        chk("cleared", 16'h0000);
        {ov_detect, soft_reset} = 7'h25;
        @(negedge core_clk);
        {ov_detect, soft_reset} = 7'h00;
        i_host.access(1'b0, ADDR_OV_FLAGS, '0, q);
        chk("soft flags", 16'h0000);
        i_host.access(1'b0, ADDR_DELAY_HB1, '0, q);
        chk("soft delay", 16'h0000);
        $display("test flags done");
    endtask
    always @(posedge core_clk) if (++cycles == 2000) begin
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        t_reset();
        t_delay();
        t_flags();
        conclude();
    end
endmodule // test_gate_driver_diag_status_regs
`default_nettype wire
